// [rtl/tx_descriptor_setup_filter.sv]
`timescale 1ns/1ps
`include "txd_consts.svh"
module tx_descriptor_setup_filter
	import txd_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        desc_valid,
	input  wire tx_desc_s    desc,
	input  wire logic [31:0] desc_addr,
	input  wire logic        tx_running,
	input  wire logic        tx_idle,
	input  wire logic        rx_busy,
	input  wire logic        setup_word_valid,
	input  wire logic [31:0] setup_word,
	input  wire logic        rx_dest_valid,
	input  wire logic [47:0] rx_dest,
	input  wire logic        promisc_mode,
	input  wire logic        accept_all_mode,
	input  wire logic        raw_status_valid,
	input  wire logic [31:0] raw_status,
	input  wire logic        int_loopback,
	output dec_s             dec_q,
	output logic             dec_valid_q,
	output logic [15:0]      frame_len_q,
	output logic             frame_len_valid_q,
	output logic             setup_word_ready_q,
	output logic             rx_disengage_q,
	output logic [31:0]      setup_status_q,
	output logic             setup_status_valid_q,
	output logic             transmit_irq_status_q,
	output logic             hash_filter_select_q,
	output logic             rx_accept_q,
	output logic             rx_accept_valid_q,
	output logic [31:0]      tx_status_q,
	output logic             tx_status_valid_q
);
	// Standard Ethernet CRC, bytes low bit first, reflected form
	function automatic logic [31:0] eth_crc(input logic [47:0] d);
		logic [31:0] c;
		c = `CRC_INIT;
		for (int i = 0; i < 48; i++) begin
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	logic [31:0] table_q [32];        // Raw setup buffer, one longword each
	setup_e      st_q;                // Setup processing state
	logic [5:0]  wcnt_q;              // Longwords loaded so far
	logic        s_ic_q;              // Latched interrupt-on-done
	logic        s_hash_q;            // Latched hash select of pending setup
	logic        s_inv_q;             // Latched inverse flag of pending setup
	logic        inv_q;               // Inverse filtering in force
	logic [31:0] s_w0_q;              // Word0 of the pending setup descriptor

	// Descriptor field decode
	wire [1:0]  f_type   = desc.w1[`W1_TYPE_HI:`W1_TYPE_LO];
	wire        f_chain  = desc.w1[`W1_CHAIN];
	wire [14:0] f_len    = desc.w2[`W2_LEN_HI:`W2_LEN_LO];
	wire        f_first  = desc.w1[`W1_FIRST];
	wire        f_last   = desc.w1[`W1_LAST];
	// A link back to itself would loop forever, so it is host-owned
	wire        self_ptr = f_chain && (desc.w3 == desc_addr);
	wire        f_host   = !desc.w0[`W0_OWN] || self_ptr;
	wire        f_zero   = (f_len == 15'h0000);
	wire        is_setup = (f_type == `TYPE_SETUP);
	// Ordinary buffer of a frame; a zero size adds nothing but still delimits
	wire        data_buf = desc_valid && !f_host && !f_chain && !is_setup;
	wire [15:0] len_sum  = (f_first ? 16'h0000 : frame_len_q) + {1'b0, f_len};
	// Setup shape check: exact size, longword aligned; bits 26/25 are filter flags here
	wire        s_bad    = (f_len != `SETUP_BYTES)
	                       || (desc.w3[1:0] != 2'h0);
	wire        s_take   = desc_valid && !f_host && !f_chain && is_setup && (st_q == ST_IDLE);
	// Later setups run only with transmit idle and no reception under way
	wire        s_go     = tx_running && tx_idle && !rx_busy;
	wire        s_word   = (st_q == ST_LOAD) && setup_word_valid && setup_word_ready_q;

	// Decoded descriptor register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_q       <= '0;
			dec_valid_q <= 1'b0;
		end else begin
			dec_valid_q <= desc_valid;
			if (desc_valid) begin
				// Physical address only; no translation offered
				dec_q.buf_addr   <= f_chain ? 32'h00000000 : desc.w3;
				dec_q.next_addr  <= f_chain ? desc.w3 : desc_addr + 32'h00000010;
				dec_q.chain      <= f_chain;
				dec_q.host_owned <= f_host;
				dec_q.skip       <= f_zero || f_chain;
				dec_q.ftype      <= f_type;
				dec_q.first      <= f_first;
				dec_q.last       <= f_last;
				dec_q.irq_done   <= desc.w1[`W1_IC];
				// Chain descriptors keep their ownership and status bits
				dec_q.wb_word0   <= !f_chain && !f_host;
			end
		end
	end

	// Frame length accumulates from first through last segment
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_len_q       <= 16'h0000;
			frame_len_valid_q <= 1'b0;
		end else begin
			frame_len_valid_q <= data_buf && f_last;
			if (data_buf) begin
				frame_len_q <= len_sum;
			end
		end
	end

	// Setup sequencing; the setup never reaches the wire or loopback
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q                  <= ST_IDLE;
			wcnt_q                <= 6'h00;
			s_ic_q                <= 1'b0;
			s_hash_q              <= 1'b0;
			s_inv_q               <= 1'b0;
			s_w0_q                <= 32'h00000000;
			setup_word_ready_q    <= 1'b0;
			rx_disengage_q        <= 1'b0;
			setup_status_q        <= 32'h00000000;
			setup_status_valid_q  <= 1'b0;
			transmit_irq_status_q <= 1'b0;
			hash_filter_select_q  <= 1'b0;
			inv_q                 <= 1'b0;
		end else begin
			setup_status_valid_q  <= 1'b0;
			transmit_irq_status_q <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (s_take) begin
						s_ic_q   <= desc.w1[`W1_IC];
						s_hash_q <= desc.w1[`W1_HASH];
						s_inv_q  <= desc.w1[`W1_INV];
						s_w0_q   <= desc.w0;
						// Malformed setup is reported and never loaded
						st_q     <= s_bad ? ST_DONE : ST_WAIT;
						s_w0_q[`W0_SE] <= s_bad;
						s_w0_q[`W0_ES] <= s_bad;
					end
				end
				ST_WAIT: begin
					if (s_go) begin
						st_q               <= ST_LOAD;
						wcnt_q             <= 6'h00;
						setup_word_ready_q <= 1'b1;
						rx_disengage_q     <= 1'b1;
					end
				end
				ST_LOAD: begin
					if (s_word) begin
						wcnt_q <= wcnt_q + 6'h01;
						if (wcnt_q == `SETUP_WORDS - 6'h01) begin
							setup_word_ready_q   <= 1'b0;
							hash_filter_select_q <= s_hash_q;
							inv_q                <= s_inv_q;
							st_q                 <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					rx_disengage_q        <= 1'b0;
					setup_status_q        <= {1'b0, s_w0_q[30:0]};
					setup_status_valid_q  <= 1'b1;
					transmit_irq_status_q <= s_ic_q;
					st_q                  <= ST_IDLE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Filter table; zeros after reset admit only the all-zero address
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 32; i++) begin
				table_q[i] <= `TABLE_RST;
			end
		end else if (s_word) begin
			table_q[wcnt_q[4:0]] <= setup_word;
		end
	end

	// Perfect entries: two longwords each, bytes low first
	logic [15:0] hit_vec;
	for (genvar g = 0; g < 16; g++) begin : g_perf
		assign hit_vec[g] = (rx_dest == {table_q[2*g+1][15:0], table_q[2*g]});
	end
	wire        any_hit   = |hit_vec;
	wire        mcast     = rx_dest[0];
	// Inverse only has effect in perfect mode with open modes off
	wire        inv_on    = inv_q && !promisc_mode && !accept_all_mode;
	wire        perf_ok   = inv_on ? !any_hit : any_hit;
	wire [31:0] crc       = eth_crc(rx_dest);
	wire [8:0]  hidx      = crc[8:0];
	// Bit index runs right to left, then into the next longword
	wire        hash_bit  = table_q[{1'b0, hidx[8:5]}][hidx[4:0]];
	wire        phys_hit  = (rx_dest == {table_q[`HASH_PHYS_W+1][15:0],
	                                     table_q[`HASH_PHYS_W]});
	wire        hash_ok   = mcast ? hash_bit : phys_hit;
	wire        open_ok   = promisc_mode || (accept_all_mode && mcast);
	wire        accept    = open_ok || (hash_filter_select_q ? hash_ok : perf_ok);

	// Filter verdict, one cycle after the destination
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_accept_q       <= 1'b0;
			rx_accept_valid_q <= 1'b0;
		end else begin
			rx_accept_valid_q <= rx_dest_valid;
			if (rx_dest_valid) begin
				rx_accept_q <= accept;
			end
		end
	end

	// Status cleanup: meaningless bits forced to zero per outcome
	wire        st_uf  = raw_status[`W0_UF] || int_loopback;
	wire        st_ec  = raw_status[`W0_EC];
	wire        st_to  = raw_status[`W0_TO];
	logic [31:0] st_mask;
	always_comb begin
		st_mask = 32'hffffffff;
		if (st_uf) begin
			st_mask[`W0_LO] = 1'b0;
			st_mask[`W0_NC] = 1'b0;
			st_mask[`W0_HF] = 1'b0;
		end
		if (st_ec) begin
			st_mask[`W0_CC_HI:`W0_CC_LO] = 4'h0;
		end
		if (st_to) begin
			st_mask[`W0_LO] = 1'b0;
			st_mask[`W0_LC] = 1'b0;
			st_mask[`W0_EC] = 1'b0;
			st_mask[`W0_HF] = 1'b0;
		end
	end

	// Cleaned transmit status register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_status_q       <= 32'h00000000;
			tx_status_valid_q <= 1'b0;
		end else begin
			tx_status_valid_q <= raw_status_valid;
			if (raw_status_valid) begin
				tx_status_q <= raw_status & st_mask;
			end
		end
	end
endmodule // tx_descriptor_setup_filter

// [rtl/txd_consts.svh]
// Summary of operation
// - Frame type: 00 data, 10 setup, 11 diagnostic
// - Virtual flag clear: word3 is buffer address
// - Chain flag: word3 points at next descriptor
// - Chain descriptor word0 left untouched after use
// - Self-pointing chain descriptor counts as host-owned
// - Skip zero-size buffers; length sums FS..LS
// - Any byte address accepted; page offset unused
// - Mask status bits meaningless for the outcome
// - Setup never sent; receiver disengaged meanwhile
// - Setup: 128 bytes, one aligned buffer, else SE+ES
// - Filter table resets to zeros
// - Setup waits: tx running, idle, no reception
// - Interrupt-on-done raises transmit interrupt status
// - Hash select: set hash, clear perfect
// - Inverse only perfect, promiscuous/all-multicast off
// - Sixteen 48-bit entries; byte0 bit0 multicast
// - Perfect: reject misses, or hits when inverse
// - Hash: CRC, nine bits index 512-bit table
// - Hash physical frames compare single address
// - Hash bits right to left, then next longword
// - First/last flags delimit frame buffers
`ifndef TXD_CONSTS_SVH
`define TXD_CONSTS_SVH
`define W0_OWN        31
`define W0_ES         15
`define W0_TO         14
`define W0_LO         11
`define W0_NC         10
`define W0_LC         9
`define W0_EC         8
`define W0_HF         7
`define W0_CC_HI      6
`define W0_CC_LO      3
`define W0_UF         1
`define W0_SE         13
`define W1_CHAIN      31
`define W1_VIRT       30
`define W1_TYPE_HI    29
`define W1_TYPE_LO    28
`define W1_FIRST      26
`define W1_LAST       25
`define W1_INV        26
`define W1_HASH       25
`define W1_IC         24
`define W2_LEN_HI     30
`define W2_LEN_LO     16
`define TYPE_DATA     2'h0
`define TYPE_SETUP    2'h2
`define TYPE_DIAG     2'h3
`define SETUP_BYTES   15'h0080
`define SETUP_WORDS   6'h20
`define TABLE_RST     32'h00000000
`define CRC_INIT      32'hffffffff
`define CRC_POLY      32'hedb88320
`define HASH_WORDS    16
`define HASH_PHYS_W   16
`endif

// [rtl/txd_pkg.sv]
package txd_pkg;
	// One transmit or setup descriptor as fetched from memory
	typedef struct packed {
		logic [31:0] w3;
		logic [31:0] w2;
		logic [31:0] w1;
		logic [31:0] w0;
	} tx_desc_s;
	// Decoded view of one descriptor
	typedef struct packed {
		logic [31:0] buf_addr;
		logic [31:0] next_addr;
		logic        chain;
		logic        host_owned;
		logic        skip;
		logic [1:0]  ftype;
		logic        first;
		logic        last;
		logic        irq_done;
		logic        wb_word0;
	} dec_s;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_LOAD, ST_DONE} setup_e;
endpackage

// [sim/host_mem_model.sv]
`timescale 1ns/1ps
// Host memory: streams the setup buffer, stalling at random
module host_mem_model (
	input  wire logic          core_clk, rst_n, setup_word_ready_q,
	input  wire logic [1023:0] sbuf,
	output logic               setup_word_valid,
	output logic [31:0]        setup_word
);
	logic [5:0] idx_q; // Next longword; 32 means all handed over
	logic       v;
	initial setup_word_valid = 1'b0;
	initial setup_word = 32'h0;
	// Advance on each word taken, restart once loading ends
	always @(posedge core_clk or negedge rst_n)
		if (!rst_n || !setup_word_ready_q) idx_q <= 6'h00;
		else if (setup_word_valid) idx_q <= idx_q + 6'h01;
	// Idle line flips to the inverse of its last value every cycle
	always @(negedge core_clk) begin
		v = setup_word_ready_q && idx_q < 6'h20 && $urandom_range(3) != 0;
		setup_word_valid <= v;
		setup_word <= v ? sbuf[{idx_q, 5'h00} +: 32] : ~setup_word;
	end
endmodule // host_mem_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import txd_pkg::*;
	logic core_clk = 0, rst_n = 0, desc_valid = 0, tx_running = 1, tx_idle = 1, rx_busy = 0;
	logic rx_dest_valid = 0, promisc_mode = 0, accept_all_mode = 0, raw_status_valid = 0;
	logic int_loopback = 0, setup_word_valid, dec_valid_q, frame_len_valid_q, setup_word_ready_q;
	logic rx_disengage_q, setup_status_valid_q, transmit_irq_status_q, hash_filter_select_q;
	logic rx_accept_q, rx_accept_valid_q, tx_status_valid_q;
	tx_desc_s desc = '0;
	dec_s dec_q;
	logic [31:0] desc_addr = 0, raw_status = 0, setup_word, setup_status_q, tx_status_q, w;
	logic [47:0] rx_dest = 0, a[16];
	logic [1023:0] sbuf = 0;
	logic [15:0] frame_len_q, sum;
	int mismatches = 0, comparisons = 0, cyc = 0, n;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
	tx_descriptor_setup_filter i_dut (.*);
	host_mem_model i_host (.*);
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) if (++cyc == 20000) begin mismatches++; test_done; end
	// Reflected CRC, low nine bits pick the hash bit
	function automatic logic [8:0] hidx(logic [47:0] d);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int i = 0; i < 48; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
		return c[8:0];
	endfunction
	// Status bits that mean nothing after the given outcome read as zero
	function automatic logic [31:0] smask(logic [31:0] s, logic lb);
		if (s[1] || lb) s = s & ~32'h00000c80;
		if (s[8]) s[6:3] = 4'h0;
		if (s[14]) s = s & ~32'h00000b80;
		return s;
	endfunction
	task automatic send(input logic [31:0] w0, w1, w2, w3, ad);
		@(negedge core_clk);
		desc = {w3, w2, w1, w0};
		desc_addr = ad;
		desc_valid = 1;
		@(negedge core_clk);
		desc_valid = 0;
	endtask
	task automatic filt(input logic [47:0] d, input logic e);
		@(negedge core_clk);
		rx_dest = d;
		rx_dest_valid = 1;
		@(negedge core_clk);
		rx_dest_valid = 0;
		`CHK({rx_accept_valid_q, rx_accept_q}, {1'b1, e})
	endtask
	// Transmitter busy, then receiver busy a while, so the load must wait
	task automatic setup(input logic [31:0] w1, input logic [14:0] len, input logic [2:0] e);
		rx_busy = 1;
		tx_idle = 0;
		send(32'h80000000, w1, {1'b0, len, 16'h0000}, 32'h00001000, 32'h00000040);
		for (n = 0; n < 300 && !setup_status_valid_q; n++) begin
			if (n == 3) tx_idle = 1;
			if (n == 6) rx_busy = 0;
			@(negedge core_clk);
		end
		rx_busy = 0;
		tx_idle = 1;
		`CHK({setup_status_valid_q, setup_status_q[15:13]}, {1'b1, e})
		`CHK(transmit_irq_status_q, w1[24])
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hbccd2278));
		repeat (3) @(negedge core_clk);
		rst_n = 1;
		`CHK({dec_valid_q, hash_filter_select_q, rx_disengage_q}, 3'b000)
		filt(48'h0, 1'b1);
		filt({$urandom, 16'h0002}, 1'b0);
		$display("test reset done");
		// Frames of three segments; zero sizes are skipped
		for (int i = 0; i < 12; i++) begin
			w = {5'h00, i % 3 == 0, i % 3 == 2, 25'h0};
			n = (i == 1 || $urandom_range(4) == 0) ? 0 : $urandom_range(4095);
			send(32'h80000000, w, {1'b0, n[14:0], 16'h0}, $urandom, 32'h100 + i * 16);
			sum = (i % 3 == 0) ? n[15:0] : sum + n[15:0];
			`CHK({dec_q.buf_addr, dec_q.chain, dec_q.skip}, {desc.w3, 1'b0, n == 0})
			`CHK({dec_q.first, dec_q.last, dec_q.ftype}, {w[26:25], 2'b00})
			`CHK({frame_len_valid_q, frame_len_q}, {w[25], sum})
		end
		send(32'h80000000, 32'h36000000, 32'h00400000, 32'h0, 32'h0);
		`CHK(dec_q.ftype, 2'b11)
		send(32'h80000000, 32'h80000000, 32'h00100000, 32'h00000200, 32'h00000300);
		`CHK({dec_q.chain, dec_q.next_addr, dec_q.host_owned, dec_q.wb_word0}, {33'h100000200, 2'b0})
		send(32'h80000000, 32'h80000000, 32'h00100000, 32'h00000300, 32'h00000300);
		`CHK({dec_q.host_owned, dec_q.wb_word0}, 2'b10)
		$display("test decode done");
		for (int i = 0; i < 16; i++) begin
			@(negedge core_clk);
			raw_status = $urandom;
			int_loopback = $urandom_range(1);
			raw_status_valid = 1;
			@(negedge core_clk);
			raw_status_valid = 0;
			`CHK({tx_status_valid_q, tx_status_q}, {1'b1, smask(raw_status, int_loopback)})
		end
		$display("test status done");
		// Perfect list with junk in the ignored upper halves
		for (int k = 0; k < 16; k++) begin
			w = $urandom;
			a[k] = {w[15:0], $urandom};
			w = $urandom;
			sbuf[k * 64 +: 64] = {w[15:0], a[k]};
		end
		setup(32'h20000000, 15'h0040, 3'b101);
		setup(32'h20000000, 15'h0080, 3'b000);
		`CHK(hash_filter_select_q, 1'b0)
		filt(a[15], 1'b1);
		filt(a[3] ^ 48'h1000, 1'b0);
		setup(32'h25000000, 15'h0080, 3'b000);
		filt(a[3], 1'b0);
		filt(a[3] ^ 48'h1000, 1'b1);
		promisc_mode = 1;
		filt(a[3], 1'b1);
		promisc_mode = 0;
		$display("test perfect done");
		for (int k = 0; k < 18; k++) sbuf[k * 32 +: 32] = $urandom;
		sbuf[512] = 1'b0;
		setup(32'h23000000, 15'h0080, 3'b000);
		`CHK(hash_filter_select_q, 1'b1)
		for (int k = 0; k < 8; k++) begin
			w = $urandom;
			a[0] = {w[15:0], $urandom} | 48'h1;
			filt(a[0], sbuf[hidx(a[0])]);
		end
		filt(sbuf[559:512], 1'b1);
		filt(sbuf[559:512] ^ 48'h10, 1'b0);
		accept_all_mode = 1;
		filt(a[0], 1'b1);
		accept_all_mode = 0;
		$display("test hash done");
		test_done;
	end
endmodule // testbench
bind tx_descriptor_setup_filter txd_monitor i_mon (.*);

// [sim/txd_monitor.sv]
`timescale 1ns/1ps
// Ties decode, setup and filter answers to the inputs that caused them
module txd_monitor
	import txd_pkg::*;
(
	input wire logic        core_clk, rst_n, desc_valid, rx_dest_valid, promisc_mode,
	input wire tx_desc_s    desc,
	input wire logic [31:0] desc_addr, raw_status, setup_status_q, tx_status_q,
	input wire logic        raw_status_valid, tx_running, tx_idle, rx_busy, tx_status_valid_q,
	input wire dec_s        dec_q,
	input wire logic        rx_accept_q, setup_word_ready_q, rx_disengage_q,
	input wire logic        setup_status_valid_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chain_link_a: assert property (
		desc_valid && desc.w1[31] |=> dec_q.chain && dec_q.next_addr == $past(desc.w3))
		else $error("chain link lost");
	buffer_addr_a: assert property (
		desc_valid && desc.w1[31:30] == 2'h0 |=> dec_q.buf_addr == $past(desc.w3))
		else $error("buffer address wrong");
	self_link_a: assert property (
		desc_valid && desc.w1[31] && desc.w3 == desc_addr |=> dec_q.host_owned)
		else $error("self link owned");
	zero_skip_a: assert property (
		desc_valid && !desc.w1[31] && desc.w2[30:16] == 15'h0 |=> dec_q.skip)
		else $error("zero size not skipped");
	promisc_accept_a: assert property (
		rx_dest_valid && promisc_mode |=> rx_accept_q) else $error("promiscuous reject");
	setup_wait_a: assert property (
		$rose(setup_word_ready_q) |-> $past(tx_running && tx_idle && !rx_busy))
		else $error("setup load too early");
	disengage_hold_a: assert property (
		setup_word_ready_q |-> rx_disengage_q) else $error("receiver engaged in load");
	setup_error_a: assert property (
		setup_status_valid_q && setup_status_q[13] |-> setup_status_q[15])
		else $error("error summary missing");
	status_mask_a: assert property (
		raw_status_valid && raw_status[1] |=> tx_status_valid_q && tx_status_q[11:10] == 2'h0)
		else $error("carrier bits kept");
endmodule // txd_monitor
